// *** hdl/bcr_core.sv ***
/*
 * Boot-configuration register read/write command logic of a serial flash.
 * Link side runs on the host serial clock, chip-enable low frames a command;
 * the register, latch and write cycle run on the system clock.
 */
`timescale 1ns/100ps
module bcr_core
    import bcr_pkg::*;
#(
    parameter int WR_CYCLES_P = WR_CYCLES
) (
    // System clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial link
    input wire logic sck,
    input wire logic ce_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // Four-line command mode select
    input wire logic qpi_mode,
    // Status and register contents
    output logic write_in_progress_flag,
    output logic write_enable_latch,
    output bcr_cfg_s boot_cfg
);

    if (WR_CYCLES_P < 1 || WR_CYCLES_P > 65535) begin : g_chk
        $error("WR_CYCLES_P out of range");
    end

    // Bit index for single-line order: low byte first, high bit first
    function automatic logic [4:0] bit_idx(input logic [5:0] c);
        bit_idx = {c[4:3], ~c[2:0]};
    endfunction : bit_idx

    // Nibble base for four-line order: low byte first, high nibble first
    function automatic logic [4:0] nib_base(input logic [5:0] c);
        nib_base = {c[2:1], ~c[0], 2'b00};
    endfunction : nib_base

    // System-domain state
    bcr_cfg_s boot_cfg_r = BOOT_CFG_RST; // No reset: models non-volatile cells
    logic [31:0] new_cfg_r;
    bcr_wr_e wst_r;
    logic [15:0] tmr_r;
    logic wip_r;
    logic wel_r;
    logic ce_d_r;
    logic tgl_d_r;

    // Link-domain state
    bcr_phase_e ph_r;
    logic [5:0] cnt_r;
    logic [7:0] opc_r;
    logic [31:0] wdat_r;
    logic armed_r = 1'b0;
    logic write_enable_cmd_tgl_r = 1'b0;

    // Crossings
    logic ce_q;
    logic armed_q;
    logic tgl_q;
    logic qpi_s;
    logic [1:0] st_s;
    logic [31:0] cfg_s;

    bcr_sync #(.W(3)) u_sync_link (
        .clk(clk),
        .d({ce_n, armed_r, write_enable_cmd_tgl_r}),
        .q({ce_q, armed_q, tgl_q})
    );

    bcr_sync #(.W(35)) u_sync_dev (
        .clk(sck),
        .d({qpi_mode, wel_r, wip_r, boot_cfg_r}),
        .q({qpi_s, st_s, cfg_s})
    );

    // Link decode helpers
    logic [7:0] opc_nxt;
    logic op_last;
    logic wr_last;
    logic [7:0] stat_b;

    assign opc_nxt = qpi_s ? {opc_r[3:0], io_in} : {opc_r[6:0], io_in[0]};
    assign op_last = qpi_s ? (cnt_r == 6'h01) : (cnt_r == 6'h07);
    assign wr_last = qpi_s ? (cnt_r == 6'h07) : (cnt_r == 6'h1F);
    always_comb begin
        stat_b = 8'h00;
        stat_b[STAT_WIP_BIT] = st_s[0];
        stat_b[STAT_WEL_BIT] = st_s[1];
    end

    // Command phase; chip-enable high ends the frame since the clock stops
    always_ff @(posedge sck or posedge ce_n) begin
        if (ce_n) begin
            ph_r <= PH_OPC;
            cnt_r <= 6'h00;
            opc_r <= 8'h00;
        end else begin
            case (ph_r)
                PH_OPC: begin
                    opc_r <= opc_nxt;
                    if (op_last) begin
                        cnt_r <= 6'h00;
                        case (opc_nxt)
                            OP_CFG_RD: ph_r <= PH_CFG_RD;
                            OP_STAT_RD: ph_r <= PH_STAT_RD;
                            // Latch gate sits on the system side: a two-nibble opcode is
                            // too short for the link-side copy of the latch to be current
                            OP_CFG_WR: ph_r <= PH_CFG_WR;
                            default: ph_r <= PH_IGNORE;
                        endcase
                    end else begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                PH_CFG_WR: begin
                    if (cnt_r != 6'h3F) begin
                        cnt_r <= cnt_r + 6'h01; // Saturate so a late edge never re-arms
                    end
                end
                PH_CFG_RD, PH_STAT_RD: cnt_r <= cnt_r + 6'h01;
                default: cnt_r <= cnt_r;
            endcase
        end
    end

    // Write data assembly; kept past the frame for the system side to take
    always_ff @(posedge sck) begin
        if (ph_r == PH_OPC) begin
            armed_r <= 1'b0;
        end else if (ph_r == PH_CFG_WR) begin
            armed_r <= wr_last;
            if (!qpi_s && cnt_r <= 6'h1F) begin
                wdat_r[bit_idx(cnt_r)] <= io_in[0];
            end else if (qpi_s && cnt_r <= 6'h07) begin
                wdat_r[nib_base(cnt_r) +: 4] <= io_in;
            end
        end
    end

    // Write-enable command raises an event toggle only while the link-side WIP copy is clear
    always_ff @(posedge sck) begin
        if (ph_r == PH_OPC && !ce_n && op_last && opc_nxt == OP_WRITE_ENABLE_CMD && !st_s[0]) begin
            write_enable_cmd_tgl_r <= ~write_enable_cmd_tgl_r;
        end
    end

    // Output drive on the falling edge, ready for the host's next rising edge
    always_ff @(negedge sck or posedge ce_n) begin
        if (ce_n) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
        end else begin
            case (ph_r)
                PH_CFG_RD: begin
                    if (qpi_s) begin
                        io_out <= cfg_s[nib_base(cnt_r) +: 4];
                        io_oe <= 4'hF;
                    end else begin
                        io_out <= {2'b00, cfg_s[bit_idx(cnt_r)], 1'b0};
                        io_oe <= 4'h2;
                    end
                end
                PH_STAT_RD: begin
                    if (qpi_s) begin
                        io_out <= cnt_r[0] ? stat_b[3:0] : stat_b[7:4];
                        io_oe <= 4'hF;
                    end else begin
                        io_out <= {2'b00, stat_b[~cnt_r[2:0]], 1'b0};
                        io_oe <= 4'h2;
                    end
                end
                default: begin
                    io_out <= 4'h0;
                    io_oe <= 4'h0;
                end
            endcase
        end
    end

    // System-side edge detection of frame end and write-enable events
    logic ce_rise;
    logic write_enable_cmd_ev;
    logic wr_go;
    assign ce_rise = ce_q && !ce_d_r;
    assign write_enable_cmd_ev = tgl_q ^ tgl_d_r;
    assign wr_go = ce_rise && armed_q && wel_r && wst_r == WS_IDLE;

    always_ff @(posedge clk) begin
        if (rst) begin
            ce_d_r <= 1'b1;
            tgl_d_r <= tgl_q; // Synchronous reset aligns, no stale event
        end else begin
            ce_d_r <= ce_q;
            tgl_d_r <= tgl_q;
        end
    end

    // Write cycle; wdat_r is static once the frame has ended
    always_ff @(posedge clk) begin
        if (rst) begin
            wst_r <= WS_IDLE;
            tmr_r <= 16'h0000;
            wip_r <= 1'b0;
            new_cfg_r <= 32'h0000_0000;
        end else begin
            case (wst_r)
                WS_IDLE: begin
                    if (wr_go) begin
                        wst_r <= WS_BUSY;
                        wip_r <= 1'b1;
                        tmr_r <= 16'(WR_CYCLES_P - 1);
                        new_cfg_r <= wdat_r;
                    end
                end
                WS_BUSY: begin
                    if (tmr_r == 16'h0000) begin
                        wst_r <= WS_IDLE;
                        wip_r <= 1'b0;
                    end else begin
                        tmr_r <= tmr_r - 16'h0001;
                    end
                end
                default: begin
                    wst_r <= WS_IDLE;
                    wip_r <= 1'b0;
                end
            endcase
        end
    end

    // Non-volatile commit at cycle end, untouched by reset
    always_ff @(posedge clk) begin
        if (!rst && wst_r == WS_BUSY && tmr_r == 16'h0000) begin
            boot_cfg_r <= bcr_cfg_s'(new_cfg_r);
        end
    end

    // Latch: a set arriving with the completion wins
    always_ff @(posedge clk) begin
        if (rst) begin
            wel_r <= 1'b0;
        end else if (write_enable_cmd_ev) begin
            wel_r <= 1'b1;
        end else if (wst_r == WS_BUSY && tmr_r == 16'h0000) begin
            wel_r <= 1'b0;
        end
    end

    assign write_in_progress_flag = wip_r;
    assign write_enable_latch = wel_r;
    assign boot_cfg = boot_cfg_r;

    // Helper: cycles spent busy
    logic [15:0] busy_cnt_r;
    always_ff @(posedge clk) begin
        if (rst || !wip_r) begin
            busy_cnt_r <= 16'h0000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 16'h0001;
        end
    end

    sequence s_wr_req;
        ce_rise && armed_q && wel_r && !wip_r;
    endsequence
    sequence s_wr_run;
        wip_r [*2];
    endsequence

    a_wr_start: assert property (@(posedge clk) disable iff (rst)
        s_wr_req |=> s_wr_run) else $error("write cycle did not start");
    a_wip_len: assert property (@(posedge clk) disable iff (rst)
        $fell(wip_r) |-> busy_cnt_r == 16'(WR_CYCLES_P))
        else $error("write cycle length wrong");
    a_wel_clear: assert property (@(posedge clk) disable iff (rst)
        $fell(wip_r) && !$past(write_enable_cmd_ev) |-> !wel_r) else $error("latch not cleared");
    a_wr_needs_wel: assert property (@(posedge clk) disable iff (rst)
        $rose(wip_r) |-> $past(wel_r) && $past(armed_q)) else $error("write without latch");
    a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
        !wip_r |=> $stable(boot_cfg_r)) else $error("register changed while idle");
    a_cfg_commit: assert property (@(posedge clk) disable iff (rst)
        $fell(wip_r) |-> boot_cfg_r == $past(new_cfg_r)) else $error("wrong value committed");
    a_wr_arm_end: assert property (@(posedge sck) disable iff (ce_n)
        ph_r == PH_CFG_WR && wr_last |=> armed_r) else $error("write not armed");
    a_wr_gate: assert property (@(posedge clk) disable iff (rst)
        ce_rise && armed_q && !wel_r |=> !wip_r)
        else $error("write accepted without latch");
    a_rd_drive: assert property (@(posedge sck) disable iff (ce_n)
        ph_r == PH_CFG_RD |-> io_oe != 4'h0) else $error("read data not driven");

endmodule : bcr_core

// *** hdl/bcr_pkg.sv ***
/*
 * Shared constants, field layout and types of the boot-configuration
 * register command logic inside a serial flash.
 * Assumes a 200 MHz system clock and a host that clocks the serial link.
 */
package bcr_pkg;

    // Command opcodes
    localparam logic [7:0] OP_CFG_RD = 8'h14;
    localparam logic [7:0] OP_CFG_WR = 8'h15;
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_STAT_RD = 8'h05;

    // Status byte bit positions
    localparam int STAT_WIP_BIT = 0;
    localparam int STAT_WEL_BIT = 1;

    // Factory contents of the register
    localparam logic [31:0] BOOT_CFG_RST = 32'h0000_0000;

    // Non-volatile write cycle time
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WR_CYCLE_NS = 10000;
    localparam int WR_CYCLES = (WR_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Register field layout
    typedef struct packed {
        logic [22:0] start_addr;
        logic [3:0] rsv;
        logic [3:0] start_dly;
        logic enable;
    } bcr_cfg_s;

    // Link command phase
    typedef enum logic [4:0] {
        PH_OPC = 5'h01,
        PH_CFG_RD = 5'h02,
        PH_STAT_RD = 5'h04,
        PH_CFG_WR = 5'h08,
        PH_IGNORE = 5'h10
    } bcr_phase_e;

    // Write cycle state
    typedef enum logic [1:0] {
        WS_IDLE = 2'h1,
        WS_BUSY = 2'h2
    } bcr_wr_e;

endpackage : bcr_pkg

// *** hdl/bcr_sync.sv ***
/*
 * Two-flop synchroniser for a bundle of levels.
 * Assumes each bit is a level or a quasi-static word stable for two clocks.
 */
`timescale 1ns/100ps
module bcr_sync #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk,
    // Levels in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    if (W < 1) begin : g_chk
        $error("W must be at least 1");
    end

    logic [W-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        meta_r <= d;
        q <= meta_r;
    end

endmodule : bcr_sync

// *** test/bcr_host.sv ***
/*
 * Host controller model for the serial link: frames commands in
 * single-line or four-line mode and collects the device's answer.
 * Assumes the device launches data on falling link clock edges.
 */
`timescale 1ns/100ps
module bcr_host (
    // Link driven by the host
    output logic sck,
    output logic ce_n,
    output logic [3:0] io_in,
    output logic qpi_mode,
    // Link driven by the device
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    logic [3:0] oe_seen;

    // Idle: deselected, clock parked low
    initial begin
        sck = 1'b0;
        ce_n = 1'b1;
        io_in = 4'hA;
        qpi_mode = 1'b0;
        oe_seen = 4'h0;
    end

    // Mode pin is synchronised on link edges, so clock while deselected
    task automatic set_mode(input logic m);
        qpi_mode = m;
        repeat (3) begin
            #24 sck = 1'b1;
            #24 sck = 1'b0;
        end
    endtask : set_mode

    // One frame: opcode, nw write bits, then nr read bits
    task automatic frame(input logic [7:0] op, input logic [31:0] wd,
                         input int nw, input int nr, output logic [63:0] rd);
        int w;
        logic [39:0] sh;
        w = qpi_mode ? 4 : 1;
        sh = {op, wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
        rd = '0;
        ce_n = 1'b0;
        for (int i = 0; i < 8 + nw + nr; i += w) begin
            // Unused lines toggle so no stale level looks valid
            io_in = (w == 4) ? sh[39:36] : {~io_in[3:1], sh[39]};
            sh = sh << w;
            #24 sck = 1'b1;
            if (i >= 8 + nw) begin
                // Undriven lines float high through the board pull-ups
                rd = (w == 4) ? {rd[59:0], io_out | ~io_oe}
                              : {rd[62:0], io_out[1] | ~io_oe[1]};
                oe_seen = io_oe;
            end
            #24 sck = 1'b0;
        end
        #24 ce_n = 1'b1;
        io_in = ~io_in;
        #40;
    endtask : frame
endmodule : bcr_host

// *** test/boot_config_register_access_tb.sv ***
/*
 * Self-checking bench: host model frames refused, truncated and valid
 * writes, status polls and wrapped reads in both link modes.
 * Assumes a shortened write cycle set through WR_CYCLES_P.
 */
`timescale 1ns/100ps
module boot_config_register_access_tb;
    import bcr_pkg::*;
    localparam int WRC = 400;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sck, ce_n, qpi_mode, write_in_progress_flag, write_enable_latch;
    logic [3:0] io_in, io_out, io_oe;
    bcr_cfg_s boot_cfg;
    logic [31:0] cur = 32'h0;
    logic [31:0] wd;
    logic [63:0] rd;
    int hi_n = 0;
    int n;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 32'h8B97;

    // System clock
    always #2.5 clk = ~clk;

    // Busy length counted on falling edges, away from the launching edge
    always @(negedge clk) if (write_in_progress_flag === 1'b1) hi_n++;

    bcr_core #(.WR_CYCLES_P(WRC)) dut (.clk(clk), .rst(rst), .sck(sck),
        .ce_n(ce_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .qpi_mode(qpi_mode), .write_in_progress_flag(write_in_progress_flag), .write_enable_latch(write_enable_latch), .boot_cfg(boot_cfg));
    bcr_host host (.sck(sck), .ce_n(ce_n), .io_in(io_in),
        .qpi_mode(qpi_mode), .io_out(io_out), .io_oe(io_oe));

    // Wire order of a word: low byte first
    function automatic logic [31:0] bswap(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : bswap

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Compared %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Bounded wait for wip to settle at v
    task automatic wait_wip(input logic v, input int lim);
        n = 0;
        while (write_in_progress_flag !== v) begin
            @(posedge clk);
            #1 n++;
            if (n > lim) begin
                bad_count++;
                $display("MISMATCH t=%0t wip wait got=%h exp=%h", $time, write_in_progress_flag, v);
                report_and_stop();
            end
        end
    endtask : wait_wip

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk(64'(boot_cfg), 64'(BOOT_CFG_RST));
        chk(64'({write_enable_latch, write_in_progress_flag}), 64'h0);
        for (int k = 0; k < 6; k++) begin
            host.set_mode(k[0]);
            wd = (k == 0) ? 32'hFFFF_FFFF : (k == 1) ? 32'h0000_0001 : $random(seed);
            // Write with latch clear must leave everything alone
            host.frame(OP_CFG_WR, ~wd, 32, 0, rd);
            #100 chk(64'({write_enable_latch, write_in_progress_flag}), 64'h0);
            chk(64'(boot_cfg), 64'(cur));
            host.frame(OP_WRITE_ENABLE_CMD, 32'h0, 0, 0, rd);
            chk(64'(write_enable_latch), 64'h1);
            // Short or long write frames are dropped
            host.frame(OP_CFG_WR, ~wd, k[1] ? 40 : (k[0] ? 28 : 31), 0, rd);
            #100 chk(64'(write_in_progress_flag), 64'h0);
            chk(64'(boot_cfg), 64'(cur));
            hi_n = 0;
            host.frame(OP_CFG_WR, wd, 32, 0, rd);
            // Poll status while the cycle runs
            host.frame(OP_STAT_RD, 32'h0, 0, 8, rd);
            chk(rd, 64'h03);
            wait_wip(1'b0, WRC + 20);
            #1 chk(64'(hi_n), 64'(WRC));
            chk(64'(boot_cfg), 64'(wd));
            chk(64'(boot_cfg.enable), 64'(wd[0]));
            cur = wd;
            host.frame(OP_STAT_RD, 32'h0, 0, 8, rd);
            chk(rd, 64'h00);
            // Read twice through the wrap
            host.frame(OP_CFG_RD, 32'h0, 0, 64, rd);
            chk(rd, {bswap(wd), bswap(wd)});
            chk(64'(host.oe_seen), k[0] ? 64'hF : 64'h2);
            // Unknown opcode leaves the lines undriven
            host.frame(8'hA5, 32'h0, 0, 8, rd);
            chk(64'(host.oe_seen), 64'h0);
            $display("Test %0d done", k);
        end
        // Reset with latch set keeps the stored word
        host.frame(OP_WRITE_ENABLE_CMD, 32'h0, 0, 0, rd);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk(64'(write_enable_latch), 64'h0);
        chk(64'(boot_cfg), 64'(cur));
        host.frame(OP_CFG_RD, 32'h0, 0, 32, rd);
        chk(rd, 64'(bswap(cur)));
        $display("Test reset done");
        report_and_stop();
    end
endmodule : boot_config_register_access_tb
